/* File: hdl/osc_defs.vh */
// Offsets, field positions, reset values and codes of the oscillator block.
`ifndef OSC_DEFS_VH
`define OSC_DEFS_VH

// Register byte offsets on the AXI4-Lite bus.
`define OSC_ADDR_W 8
`define OSC_OFS_CONTROL 8'h00
`define OSC_OFS_UNLOCK 8'h04
`define OSC_OFS_IRQ_STAT 8'h08
`define OSC_OFS_IRQ_MASK 8'h0C
`define OSC_OFS_SWITCH 8'h10

// Field positions inside oscillator_control.
`define OSC_MULT_HI 18
`define OSC_MULT_LO 16
`define OSC_ACT_HI 14
`define OSC_ACT_LO 12
`define OSC_REQ_HI 10
`define OSC_REQ_LO 8
`define OSC_LOCK_BIT 7
`define OSC_USB_LOCK_BIT 6
`define OSC_SYS_LOCK_BIT 5
`define OSC_SLEEP_BIT 4
`define OSC_FAIL_BIT 3

// Field positions inside the switch register.
`define OSC_GO_BIT 0
`define OSC_DIV_HI 4
`define OSC_DIV_LO 2

// Reset values of fields that no configuration setting supplies.
`define OSC_MULT_RST 3'h0
`define OSC_DIV_RST 3'h0
`define OSC_MASK_RST 4'h0

// Unlock keys; the values are arbitrary.
`define OSC_KEY_ONE 32'h5A5AC3C3
`define OSC_KEY_TWO 32'hA5A53C3C

// Clock source codes.
`define OSC_SRC_FAST_RC 3'h0
`define OSC_SRC_FAST_RC_MULT 3'h1
`define OSC_SRC_PRIMARY 3'h2
`define OSC_SRC_PRIMARY_MULT 3'h3
`define OSC_SRC_SECONDARY 3'h4
`define OSC_SRC_LOW_POWER_RC 3'h5
`define OSC_SRC_FAST_RC_DIV16 3'h6
`define OSC_SRC_FAST_RC_DIVSEL 3'h7

// Bus responses.
`define OSC_RESP_OKAY 2'h0
`define OSC_RESP_SLVERR 2'h2

`endif

/* File: hdl/osc_unlock.v */
// Key sequence detector that opens the control register for one write.
`timescale 1ns/10ps
`include "osc_defs.vh"

module osc_unlock (
	input wire aclk,
	input wire aresetn,
	input wire key_wr,
	input wire [31:0] key_data,
	input wire consume,
	output reg unlocked_q
);

	localparam ST_LOCKED = 3'b001;
	localparam ST_HALF = 3'b010;
	localparam ST_OPEN = 3'b100;

	reg [2:0] st_q;
	reg [2:0] st_d;

	// Two keys back to back open the register; any other key or one
	// attempted control write closes it again.
	always @* begin
		st_d = st_q;
		case (st_q)
		ST_LOCKED: begin
			if (key_wr && key_data == `OSC_KEY_ONE)
				st_d = ST_HALF;
		end
		ST_HALF, ST_OPEN: begin
			if (consume)
				st_d = ST_LOCKED;
			else if (key_wr && st_q == ST_HALF &&
				key_data == `OSC_KEY_TWO)
				st_d = ST_OPEN;
			else if (key_wr && key_data == `OSC_KEY_ONE)
				st_d = ST_HALF;
			else if (key_wr)
				st_d = ST_LOCKED;
		end
		default: begin
			st_d = ST_LOCKED;
		end
		endcase
	end

	// State and the open flag, which the top reads straight from a flop.
	always @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_LOCKED;
			unlocked_q <= 1'b0;
		end else begin
			st_q <= st_d;
			unlocked_q <= (st_d == ST_OPEN);
		end
	end

endmodule // osc_unlock

/* File: hdl/osc_ctrl.v */
// Oscillator source control with an AXI4-Lite register slave.
`timescale 1ns/10ps
`include "osc_defs.vh"


module osc_ctrl #(
	parameter ADDR_W = `OSC_ADDR_W
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [2:0] default_source_config,
	input wire [1:0] switch_monitor_config,
	input wire usb_pll_lock_in,
	input wire sys_pll_lock_in,
	input wire monitor_fail_in,
	input wire wait_exec_in,
	input wire clk_switch_ack_in,
	output reg clk_switch_req_q,
	output reg [2:0] clk_switch_target_q,
	output reg [4:0] mult_factor_q,
	output reg [6:0] src_sel_q,
	output reg sleep_enter_q,
	output reg idle_enter_q,
	output reg irq_q
);

	localparam SW_IDLE = 3'b001;
	localparam SW_WAIT = 3'b010;
	localparam SW_DONE = 3'b100;

	// Multiplication factor of a multiplier code.
	function [4:0] mult_of;
		input [2:0] code;
		begin
			case (code)
			3'h5: mult_of = 5'h14;
			3'h6: mult_of = 5'h15;
			3'h7: mult_of = 5'h18;
			default: mult_of = 5'h0F + {2'h0, code};
			endcase
		end
	endfunction

	// Byte strobes widened to a bit mask.
	function [31:0] lane_mask;
		input [3:0] strb;
		begin
			lane_mask = {{8{strb[3]}}, {8{strb[2]}},
				{8{strb[1]}}, {8{strb[0]}}};
		end
	endfunction

	// Word address with the byte offset dropped.
	function [ADDR_W-1:0] word_of;
		input [ADDR_W-1:0] addr;
		begin
			word_of = {addr[ADDR_W-1:2], 2'h0};
		end
	endfunction

	// True for an address that holds a register.
	function is_mapped;
		input [ADDR_W-1:0] addr;
		begin
			case (word_of(addr))
			`OSC_OFS_CONTROL, `OSC_OFS_UNLOCK, `OSC_OFS_IRQ_STAT,
			`OSC_OFS_IRQ_MASK, `OSC_OFS_SWITCH: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// Path select with one bit per path; a derived path also sets its source bit: {divsel, div16, low-power, secondary,
	// primary, multiplier, fast RC}.
	function [6:0] src_decode;
		input [2:0] src;
		begin
			case (src)
			`OSC_SRC_FAST_RC: src_decode = 7'h01;
			`OSC_SRC_FAST_RC_MULT: src_decode = 7'h03;
			`OSC_SRC_PRIMARY: src_decode = 7'h04;
			`OSC_SRC_PRIMARY_MULT: src_decode = 7'h06;
			`OSC_SRC_SECONDARY: src_decode = 7'h08;
			`OSC_SRC_LOW_POWER_RC: src_decode = 7'h10;
			`OSC_SRC_FAST_RC_DIV16: src_decode = 7'h21;
			default: src_decode = 7'h41;
			endcase
		end
	endfunction

	reg aw_hold_q;
	reg w_hold_q;
	reg [ADDR_W-1:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg [2:0] mult_q;
	reg [2:0] req_q;
	reg [2:0] active_q;
	reg lock_q;
	reg sleep_q;
	reg fail_q;
	reg usb_lock_q;
	reg sys_lock_q;
	reg [2:0] div_q;
	reg [2:0] sw_st_q;
	reg [3:0] stat_q;
	reg [3:0] mask_q;
	reg [31:0] ctl_img;
	reg [31:0] rd_img;
	wire unlocked;

	wire wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	wire [ADDR_W-1:0] wr_word = word_of(awaddr_q);
	wire [31:0] wmask = lane_mask(wstrb_q);
	wire [31:0] wbits = wdata_q & wmask;
	wire wr_ctl = wr_fire & (wr_word == `OSC_OFS_CONTROL);
	wire wr_key = wr_fire & (wr_word == `OSC_OFS_UNLOCK);
	wire wr_stat = wr_fire & (wr_word == `OSC_OFS_IRQ_STAT);
	wire wr_mask = wr_fire & (wr_word == `OSC_OFS_IRQ_MASK);
	wire wr_sw = wr_fire & (wr_word == `OSC_OFS_SWITCH);
	wire ctl_ok = wr_ctl & unlocked;
	wire [31:0] ctl_new = (ctl_img & ~wmask) | wbits;
	wire [31:0] sw_new = ({27'h0, div_q, 2'h0} & ~wmask) | wbits;
	// Lock only bites when switching and monitoring is disabled.
	wire sel_locked = switch_monitor_config[1] & lock_q;
	wire go = wr_sw & wbits[`OSC_GO_BIT] & ~sel_locked;
	wire sw_done = (sw_st_q == SW_DONE);
	wire usb_lost = usb_lock_q & ~usb_pll_lock_in;
	wire sys_lost = sys_lock_q & ~sys_pll_lock_in;
	wire [3:0] events = {usb_lost, sys_lost, sw_done, monitor_fail_in};
	// A new event wins over a write-one-to-clear in the same cycle.
	wire [3:0] stat_d = (stat_q & ~({4{wr_stat}} & wbits[3:0])) | events;
	wire [3:0] mask_d = wr_mask ? wbits[3:0] : mask_q;

	// The key register feeds the unlock detector; the register opens
	// for exactly one attempted control write.
	osc_unlock u_unlock (
		.aclk(aclk),
		.aresetn(aresetn),
		.key_wr(wr_key),
		.key_data(wdata_q),
		.consume(wr_ctl),
		.unlocked_q(unlocked)
	);

	// Read image of oscillator_control; gaps read as zero.
	always @* begin
		ctl_img = 32'h0;
		ctl_img[`OSC_MULT_HI:`OSC_MULT_LO] = mult_q;
		ctl_img[`OSC_ACT_HI:`OSC_ACT_LO] = active_q;
		ctl_img[`OSC_REQ_HI:`OSC_REQ_LO] = req_q;
		ctl_img[`OSC_LOCK_BIT] = lock_q;
		ctl_img[`OSC_USB_LOCK_BIT] = usb_lock_q;
		ctl_img[`OSC_SYS_LOCK_BIT] = sys_lock_q;
		ctl_img[`OSC_SLEEP_BIT] = sleep_q;
		ctl_img[`OSC_FAIL_BIT] = fail_q;
	end

	// Read multiplexer; the key register reads back as zero.
	always @* begin
		case (word_of(s_axi_araddr))
		`OSC_OFS_CONTROL: rd_img = ctl_img;
		`OSC_OFS_IRQ_STAT: rd_img = {28'h0, stat_q};
		`OSC_OFS_IRQ_MASK: rd_img = {28'h0, mask_q};
		`OSC_OFS_SWITCH: rd_img = {27'h0, div_q, 1'b0,
			~sw_st_q[0]};
		default: rd_img = 32'h0;
		endcase
	end

	// Write channels are taken independently and held until both are in.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `OSC_RESP_OKAY;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= {ADDR_W{1'b0}};
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (!aw_hold_q && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (!w_hold_q && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_fire) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(awaddr_q) ?
					`OSC_RESP_OKAY : `OSC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Reads answer one cycle after the address is taken.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `OSC_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_img;
				s_axi_rresp <= is_mapped(s_axi_araddr) ?
					`OSC_RESP_OKAY : `OSC_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Control fields. The lock bit can only be set by software, so a
	// locked part stays locked until the next reset.
	always @(posedge aclk) begin
		if (!aresetn) begin
			req_q <= default_source_config;
			active_q <= default_source_config;
			mult_q <= `OSC_MULT_RST;
			lock_q <= 1'b0;
			sleep_q <= 1'b0;
			fail_q <= 1'b0;
		end else begin
			if (ctl_ok && !sel_locked) begin
				req_q <= ctl_new[`OSC_REQ_HI:`OSC_REQ_LO];
				mult_q <= ctl_new[`OSC_MULT_HI:`OSC_MULT_LO];
			end
			if (ctl_ok) begin
				lock_q <= lock_q | ctl_new[`OSC_LOCK_BIT];
				sleep_q <= ctl_new[`OSC_SLEEP_BIT];
			end
			// A failure in the clearing cycle keeps the flag set.
			if (monitor_fail_in)
				fail_q <= 1'b1;
			else if (ctl_ok && !ctl_new[`OSC_FAIL_BIT])
				fail_q <= 1'b0;
			if (sw_done)
				active_q <= clk_switch_target_q;
		end
	end

	// Lock inputs are sampled so the status bits are glitch free.
	always @(posedge aclk) begin
		if (!aresetn) begin
			usb_lock_q <= 1'b0;
			sys_lock_q <= 1'b0;
		end else begin
			usb_lock_q <= usb_pll_lock_in;
			sys_lock_q <= sys_pll_lock_in;
		end
	end

	// Divider select lives beside the switch trigger.
	always @(posedge aclk) begin
		if (!aresetn)
			div_q <= `OSC_DIV_RST;
		else if (wr_sw)
			div_q <= sw_new[`OSC_DIV_HI:`OSC_DIV_LO];
	end

	// Switch sequencer: the mux is asked for the target and the active
	// field follows only after its acknowledge, so a slow mux never
	// shows a source it is not yet running on.
	always @(posedge aclk) begin
		if (!aresetn) begin
			sw_st_q <= SW_IDLE;
			clk_switch_req_q <= 1'b0;
			clk_switch_target_q <= default_source_config;
		end else begin
			case (sw_st_q)
			SW_IDLE: begin
				if (go) begin
					clk_switch_target_q <= req_q;
					if (req_q == active_q) begin
						sw_st_q <= SW_DONE;
					end else begin
						clk_switch_req_q <= 1'b1;
						sw_st_q <= SW_WAIT;
					end
				end
			end
			SW_WAIT: begin
				if (clk_switch_ack_in) begin
					clk_switch_req_q <= 1'b0;
					sw_st_q <= SW_DONE;
				end
			end
			SW_DONE: begin
				sw_st_q <= SW_IDLE;
			end
			default: begin
				sw_st_q <= SW_IDLE;
				clk_switch_req_q <= 1'b0;
			end
			endcase
		end
	end

	// Interrupt status, mask and the level output.
	always @(posedge aclk) begin
		if (!aresetn) begin
			stat_q <= 4'h0;
			mask_q <= `OSC_MASK_RST;
			irq_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q <= |(stat_d & mask_d);
		end
	end

	// Decoded drives towards the clock tree and the power manager.
	always @(posedge aclk) begin
		if (!aresetn) begin
			mult_factor_q <= 5'h0F;
			src_sel_q <= 7'h01;
			sleep_enter_q <= 1'b0;
			idle_enter_q <= 1'b0;
		end else begin
			mult_factor_q <= mult_of(mult_q);
			src_sel_q <= src_decode(active_q);
			// Nothing but an executed wait can power the core down.
			sleep_enter_q <= wait_exec_in & sleep_q;
			idle_enter_q <= wait_exec_in & ~sleep_q;
		end
	end

endmodule // osc_ctrl

/* File: testbench/osc_ctrl_monitor.sv */
// Assertion checker bound to the oscillator control block.
`timescale 1ns/10ps
module osc_ctrl_monitor (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire wait_exec_in,
	input wire clk_switch_ack_in,
	input wire clk_switch_req_q,
	input wire [4:0] mult_factor_q,
	input wire [6:0] src_sel_q,
	input wire sleep_enter_q,
	input wire idle_enter_q
);
	// One clock domain, so clocking and reset are declared once.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Steps of a bus write and of a low-power entry.
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence pwr_pulse;
		sleep_enter_q || idle_enter_q;
	endsequence

	a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read response late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	a_wait_pulse: assert property (
		wait_exec_in |=> sleep_enter_q != idle_enter_q)
		else $error("wait gave no single mode pulse");
	a_pwrdn_cause: assert property (
		pwr_pulse |-> $past(wait_exec_in)) else $error("power-down unasked");
	a_mult_legal: assert property (
		mult_factor_q inside {[15:21], 24}) else $error("bad factor");
	a_src_code: assert property (
		src_sel_q inside {7'h01, 7'h03, 7'h04, 7'h06, 7'h08, 7'h10, 7'h21,
		7'h41}) else $error("bad path select");
	a_req_hold: assert property (
		clk_switch_req_q && !clk_switch_ack_in |=> clk_switch_req_q)
		else $error("switch request dropped early");
	a_req_drop: assert property (
		clk_switch_req_q && clk_switch_ack_in |=> !clk_switch_req_q)
		else $error("switch request stuck");
	a_src_after_ack: assert property (
		$past(aresetn, 4) && $changed(src_sel_q) |-> $past(clk_switch_ack_in,
		2) || $past(clk_switch_ack_in, 3) || $past(clk_switch_ack_in, 4))
		else $error("source changed without switch");
endmodule // osc_ctrl_monitor

bind osc_ctrl osc_ctrl_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .wait_exec_in, .clk_switch_ack_in, .clk_switch_req_q,
	.mult_factor_q, .src_sel_q, .sleep_enter_q, .idle_enter_q);

/* File: testbench/oscillator_source_control_tb_top.sv */
// Self-checking bench for the oscillator source control block.
`timescale 1ns/10ps
`include "osc_defs.vh"
`define CHK(n, s, e) begin samples_checked++; if ((e) !== (s)) begin \
	num_errors++; $display("unexpected %s exp %h got %h", n, e, s); end end
module oscillator_source_control_tb_top;
	typedef struct {bit w; logic [1:0] r; logic [31:0] d, m;} osc_note_t;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, ulk = 1, slk = 0, fail = 0, wt = 0;
	logic ack = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, seed = 32'h000127F1;
	logic [2:0] dflt = 3'h5;
	logic [1:0] smc = 2'h0;
	wire awready, wready, bvalid, arready, rvalid, req, sleep, idle, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [2:0] tgt;
	wire [4:0] mult;
	wire [6:0] ssel;
	osc_note_t q[$], e;
	int num_errors = 0, samples_checked = 0, i;
	logic [6:0] enc [8] = '{7'h01, 7'h03, 7'h04, 7'h06, 7'h08, 7'h10,
		7'h21, 7'h41};

	osc_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .default_source_config(dflt),
		.switch_monitor_config(smc), .usb_pll_lock_in(ulk),
		.sys_pll_lock_in(slk), .monitor_fail_in(fail), .wait_exec_in(wt),
		.clk_switch_ack_in(ack), .clk_switch_req_q(req),
		.clk_switch_target_q(tgt), .mult_factor_q(mult), .src_sel_q(ssel),
		.sleep_enter_q(sleep), .idle_enter_q(idle), .irq_q(irq));

	// Free-running 100 MHz clock.
	always #5 aclk = ~aclk;

	// Xorshift source; fixed start keeps every run identical.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] cv(input [2:0] m, a, r, input lk, sl, fl);
		return {13'h0, m, 1'b0, a, 1'b0, r, lk, ulk, slk, sl, fl, 3'h0};
	endfunction

	function automatic logic [4:0] fac(input [2:0] c);
		return c < 5 ? 5'h0F + c : (c == 5 ? 5'h14 : (c == 6 ? 5'h15 : 5'h18));
	endfunction

	task print_verdict();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Master holds each channel until its own handshake edge.
	task automatic bus(input bit w, input [7:0] a, input [31:0] d,
		input [31:0] m = 32'hFFFFFFFF, input [1:0] r = 2'h0);
		int n;
		q.push_back('{w, r, d, m});
		@(posedge aclk);
		if (w) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1;
			wvalid <= 1;
			bready <= 1;
		end else begin
			araddr <= a;
			arvalid <= 1;
			rready <= 1;
		end
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (arready) arvalid <= 0;
			if ((bvalid && bready) || (rvalid && rready)) break;
		end
		bready <= 0;
		rready <= 0;
		if (n == 50) begin
			num_errors++;
			print_verdict();
		end
	endtask

	// Every control write needs a fresh key pair first.
	task cw(input [31:0] d);
		bus(1, `OSC_OFS_UNLOCK, `OSC_KEY_ONE);
		bus(1, `OSC_OFS_UNLOCK, `OSC_KEY_TWO);
		bus(1, `OSC_OFS_CONTROL, d);
	endtask

	task rst(input [2:0] d);
		@(posedge aclk);
		aresetn <= 0;
		dflt <= d;
		tick(20);
		aresetn <= 1;
		tick(2);
	endtask

	// Result watcher: the oldest note is matched to each bus answer.
	always @(posedge aclk) begin
		if ((bvalid && bready) || (rvalid && rready)) begin
			if (q.size() == 0) `CHK("note", 1'b0, 1'b1)
			else begin
				e = q.pop_front();
				`CHK("resp", e.w ? bresp : rresp, e.r)
				if (!e.w) `CHK("rdata", rdata & e.m, e.d & e.m)
			end
		end
	end

	initial begin
		rst(3'h5);
		`CHK("mult", mult, 5'h0F)
		`CHK("ssel", ssel, enc[5])
		bus(0, `OSC_OFS_CONTROL, cv(0, 5, 5, 0, 0, 0));
		bus(1, `OSC_OFS_CONTROL, 32'h00070000);
		bus(0, `OSC_OFS_CONTROL, cv(0, 5, 5, 0, 0, 0));
		$display("reset and unlock test done");
		for (i = 0; i < 8; i++) begin
			cw({13'h0, i[2:0], 16'hFD00});
			bus(0, `OSC_OFS_CONTROL, cv(i[2:0], 5, 5, 0, 0, 0));
			`CHK("mult", mult, fac(i[2:0]))
		end
		$display("multiplier test done");
		for (i = 0; i < 8; i++) begin
			cw({13'h0, 3'h7, 5'h0, i[2:0], 8'h0});
			bus(1, `OSC_OFS_IRQ_MASK, {30'h0, i[0], 1'b0});
			bus(1, `OSC_OFS_SWITCH, 32'h1);
			for (int n = 0; n < 20 && req !== 1'b1; n++) @(posedge aclk);
			if (req !== 1'b1) begin
				num_errors++;
				print_verdict();
			end
			`CHK("tgt", tgt, i[2:0])
			tick(rnd() & 3);
			bus(0, `OSC_OFS_SWITCH, 32'h1);
			`CHK("ssel", ssel, enc[i == 0 ? 5 : i - 1])
			@(posedge aclk);
			ack <= 1;
			@(posedge aclk);
			ack <= 0;
			tick(3);
			`CHK("ssel", ssel, enc[i])
			`CHK("irq", irq, i[0])
			bus(0, `OSC_OFS_CONTROL, cv(7, i[2:0], i[2:0], 0, 0, 0));
			bus(1, `OSC_OFS_IRQ_STAT, 32'h2);
			bus(0, `OSC_OFS_IRQ_STAT, 32'h0, 32'h2);
			`CHK("irq", irq, 1'b0)
		end
		$display("switch test done");
		for (i = 0; i < 2; i++) begin
			cw({13'h0, 3'h7, 5'h0, 3'h7, 3'h0, i[0], 4'h0});
			@(posedge aclk);
			wt <= 1;
			@(posedge aclk);
			wt <= 0;
			#1;
			`CHK("sleep", sleep, i[0])
			`CHK("idle", idle, ~i[0])
		end
		$display("wait test done");
		bus(1, `OSC_OFS_IRQ_MASK, 32'h1);
		slk <= 1;
		ulk <= 0;
		fail <= 1;
		@(posedge aclk);
		fail <= 0;
		bus(0, `OSC_OFS_CONTROL, cv(7, 7, 7, 0, 1, 1));
		`CHK("irq", irq, 1'b1)
		cw(cv(7, 7, 7, 0, 1, 0));
		bus(0, `OSC_OFS_CONTROL, cv(7, 7, 7, 0, 1, 0));
		bus(1, `OSC_OFS_IRQ_STAT, 32'h1);
		`CHK("irq", irq, 1'b0)
		$display("clock fail test done");
		cw(cv(7, 7, 7, 1, 1, 0));
		cw(cv(3, 7, 2, 1, 1, 0));
		@(posedge aclk);
		smc <= 2'h2;
		cw(cv(1, 7, 4, 1, 1, 0));
		bus(0, `OSC_OFS_CONTROL, cv(3, 7, 2, 1, 1, 0));
		`CHK("mult", mult, fac(3))
		bus(1, `OSC_OFS_SWITCH, 32'h1D);
		tick(4);
		`CHK("req", req, 1'b0)
		bus(0, `OSC_OFS_SWITCH, 32'h1C);
		$display("lock test done");
		rst(3'h2);
		`CHK("ssel", ssel, enc[2])
		bus(0, `OSC_OFS_CONTROL, cv(0, 2, 2, 0, 0, 0));
		bus(1, 8'h14, rnd(), 32'h0, `OSC_RESP_SLVERR);
		bus(0, 8'h14, 32'h0, 32'hFFFFFFFF, `OSC_RESP_SLVERR);
		$display("second reset and unmapped test done");
		tick(2);
		print_verdict();
	end
endmodule // oscillator_source_control_tb_top
